// *** tmz_pkg.sv ***
// Constants, types and register map of the timer/counter block
package tmz_pkg;

    // ********************************
    // Register map (index, byte address)
    // ********************************
    localparam logic [7:0] IDX_TIMER_COUNT  = 8'h01;
    localparam logic [7:0] IDX_TIMER_CONFIG = 8'h02;
    localparam logic [7:0] IDX_TIMER_STATUS = 8'h03;
    localparam logic [7:0] ADDR_TIMER_COUNT  = 8'(IDX_TIMER_COUNT * 4);
    localparam logic [7:0] ADDR_TIMER_CONFIG = 8'(IDX_TIMER_CONFIG * 4);
    localparam logic [7:0] ADDR_TIMER_STATUS = 8'(IDX_TIMER_STATUS * 4);

    // ********************************
    // Config fields and reset values
    // ********************************
    localparam int         CFG_SRC_BIT   = 5;
    localparam int         CFG_EDGE_BIT  = 4;
    localparam int         CFG_PSA_BIT   = 3;
    localparam int         CFG_PS_LSB    = 0;
    localparam int         CFG_PS_W      = 3;
    localparam logic [7:0] CFG_RESET     = 8'hff;
    localparam logic [7:0] PC_RESET      = 8'hff;
    localparam logic [11:0] IR_NOP       = 12'h000;

    // ********************************
    // Status fields
    // ********************************
    localparam int STS_PHASE_LSB = 0;
    localparam int STS_INH_LSB   = 2;
    localparam int STS_PSA_BIT   = 4;

    // ********************************
    // Timing counts
    // ********************************
    localparam logic [1:0] INHIBIT_CYCLES = 2'd2;
    localparam int         PRESC_W        = 8;

    typedef enum logic [1:0] {
        PH_ONE   = 2'b00,
        PH_TWO   = 2'b01,
        PH_THREE = 2'b10,
        PH_FOUR  = 2'b11
    } tmz_phase_t;

endpackage

// *** tmz_prescaler.sv ***
// Shared 8-bit prescaler with power-of-two tap select
`timescale 1ns/1ps
module tmz_prescaler
    import tmz_pkg::*;
(
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    // Control
    input  wire logic                tickIn,
    input  wire logic                clear,
    input  wire logic [CFG_PS_W-1:0] ratioSel,
    // Divided output
    output logic                     tickOut_ff
);

    logic [PRESC_W-1:0] count_ff;
    logic [PRESC_W-1:0] nxt_count;
    logic               nxt_tickOut;
    logic [PRESC_W-1:0] tapMask;

    // ****************************************
    // Divider: mask of ratio+1 low ones
    // ****************************************
    always_comb begin
        tapMask     = PRESC_W'((9'h002 << ratioSel) - 9'h001);
        nxt_count   = count_ff;
        nxt_tickOut = 1'b0;
        if (clear) begin
            nxt_count = '0;
        end else if (tickIn) begin
            nxt_count = count_ff + 8'h01;
            // Output once every 2^(ratio+1) input ticks
            nxt_tickOut = ((count_ff | ~tapMask) == 8'hff);
        end
    end

    // Count is internal only; no register path reads it, a count register write clears it unless it serves the watchdog
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff   <= '0;
            tickOut_ff <= 1'b0;
        end else begin
            count_ff   <= nxt_count;
            tickOut_ff <= nxt_tickOut;
        end
    end

endmodule // tmz_prescaler

// *** tmz_timer0.sv ***
// Timer/counter with core phase timing, prescaler and APB register slave
`timescale 1ns/1ps
module tmz_timer0
    import tmz_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata_ff,
    output logic             pready_ff,
    output logic             pslverr_ff,
    // External count clock pin
    input  wire logic        extCountClockPin,
    // Watchdog side of the prescaler
    input  wire logic        wdtTickIn,
    output logic             wdtTick_ff,
    // Core timing
    input  wire logic        branchReq,
    input  wire logic [7:0]  branchTarget,
    input  wire logic [11:0] instrWord,
    output logic [3:0]       phaseVec_ff,
    output logic [7:0]       programCounter_ff,
    output logic [11:0]      instrReg_ff,
    output logic             pipeFlush_ff
);

    // ****************************************
    // Declarations
    // ****************************************
    tmz_phase_t  phase_ff;
    tmz_phase_t  nxt_phase;
    logic [3:0]  nxt_phaseVec;
    logic        cycleEnd;

    logic [7:0]  programCounter_nx;
    logic [11:0] nxt_instrReg;
    logic        nxt_pipeFlush;
    logic        branchPend_ff;
    logic        nxt_branchPend;
    logic [7:0]  branchTgt_ff;
    logic [7:0]  nxt_branchTgt;

    logic [2:0]  pinSync_ff;
    logic [2:0]  nxt_pinSync;
    logic        pinLevel_ff;
    logic        nxt_pinLevel;
    logic        extEdge;

    logic [7:0]  timerCount_ff;
    logic [7:0]  nxt_timerCount;
    logic [7:0]  timerConfig_ff;
    logic [7:0]  nxt_timerConfig;
    logic [1:0]  inhibit_ff;
    logic [1:0]  nxt_inhibit;

    logic        srcSel;
    logic        edgeSel;
    logic        presToWdt;
    logic        srcTick;
    logic        prescIn;
    logic        prescOut;
    logic        timerTick;
    logic        nxt_wdtTick;

    logic        accessPend;
    logic        commit;
    logic        wrCount;
    logic        wrConfig;
    logic        addrHit;
    tmz_phase_t  targetPhase;
    logic        nxt_pready;
    logic        nxt_pslverr;
    logic [31:0] nxt_prdata;
    logic [31:0] readMux;

    // ****************************************
    // Phase generator
    // ****************************************
    always_comb begin
        case (phase_ff)
            PH_ONE:   nxt_phase = PH_TWO;
            PH_TWO:   nxt_phase = PH_THREE;
            PH_THREE: nxt_phase = PH_FOUR;
            PH_FOUR:  nxt_phase = PH_ONE;
            default:  nxt_phase = PH_ONE;
        endcase
        nxt_phaseVec = 4'h1 << nxt_phase;
        cycleEnd     = (phase_ff == PH_FOUR);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff    <= PH_FOUR;
            phaseVec_ff <= 4'h8;
        end else begin
            phase_ff    <= nxt_phase;
            phaseVec_ff <= nxt_phaseVec;
        end
    end

    // ****************************************
    // Fetch pipeline
    // ****************************************
    always_comb begin
        programCounter_nx = programCounter_ff;
        nxt_instrReg      = instrReg_ff;
        nxt_pipeFlush     = pipeFlush_ff;
        nxt_branchPend    = branchPend_ff;
        nxt_branchTgt     = branchTgt_ff;
        if (branchReq) begin
            nxt_branchPend = 1'b1;
            nxt_branchTgt  = branchTarget;
        end
        if (nxt_phase == PH_ONE) begin
            if (branchPend_ff) begin
                // Prefetched word is stale: this cycle runs a no-op
                programCounter_nx = branchTgt_ff;
                nxt_pipeFlush     = 1'b1;
                nxt_branchPend    = branchReq;
            end else begin
                programCounter_nx = programCounter_ff + 8'h01;
                nxt_pipeFlush     = 1'b0;
            end
        end
        if (nxt_phase == PH_FOUR) begin
            nxt_instrReg = pipeFlush_ff ? IR_NOP : instrWord;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            programCounter_ff <= PC_RESET;
            instrReg_ff       <= IR_NOP;
            pipeFlush_ff      <= 1'b0;
            branchPend_ff     <= 1'b0;
            branchTgt_ff      <= 8'h00;
        end else begin
            programCounter_ff <= programCounter_nx;
            instrReg_ff       <= nxt_instrReg;
            pipeFlush_ff      <= nxt_pipeFlush;
            branchPend_ff     <= nxt_branchPend;
            branchTgt_ff      <= nxt_branchTgt;
        end
    end

    // ****************************************
    // External pin synchroniser and edge filter
    // ****************************************
    always_comb begin
        nxt_pinSync  = {pinSync_ff[1:0], extCountClockPin};
        nxt_pinLevel = pinLevel_ff;
        extEdge      = 1'b0;
        // Stage one is only read by stage two
        if ((pinSync_ff[1] == pinSync_ff[2]) && (pinSync_ff[2] != pinLevel_ff)) begin
            nxt_pinLevel = pinSync_ff[2];
            extEdge      = edgeSel ? ~pinSync_ff[2] : pinSync_ff[2];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinSync_ff  <= 3'b000;
            pinLevel_ff <= 1'b0;
        end else begin
            pinSync_ff  <= nxt_pinSync;
            pinLevel_ff <= nxt_pinLevel;
        end
    end

    // ****************************************
    // Count source and prescaler routing
    // ****************************************
    assign srcSel    = timerConfig_ff[CFG_SRC_BIT];
    assign edgeSel   = timerConfig_ff[CFG_EDGE_BIT];
    assign presToWdt = timerConfig_ff[CFG_PSA_BIT];
    assign srcTick   = srcSel ? extEdge : cycleEnd;
    // Exclusive use: one consumer sees the divider; with presToWdt set the timer bypasses it, otherwise wdtTick_ff stays low
    assign prescIn   = presToWdt ? wdtTickIn : srcTick;
    assign timerTick = presToWdt ? srcTick : prescOut;
    assign nxt_wdtTick = presToWdt & prescOut;

    tmz_prescaler u_prescaler (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .tickIn     (prescIn),
        .clear      (wrCount & ~presToWdt),
        .ratioSel   (timerConfig_ff[CFG_PS_LSB +: CFG_PS_W]),
        .tickOut_ff (prescOut)
    );

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdtTick_ff <= 1'b0;
        end else begin
            wdtTick_ff <= nxt_wdtTick;
        end
    end

    // ****************************************
    // APB access timing
    // ****************************************
    assign accessPend = psel & penable & ~pready_ff;
    assign commit     = psel & penable & pready_ff;
    assign addrHit    = (paddr == ADDR_TIMER_COUNT) || (paddr == ADDR_TIMER_CONFIG) ||
                        (paddr == ADDR_TIMER_STATUS);
    assign wrCount    = commit & pwrite & (paddr == ADDR_TIMER_COUNT);
    assign wrConfig   = commit & pwrite & (paddr == ADDR_TIMER_CONFIG);

    always_comb begin
        readMux = 32'h0000_0000;
        case (paddr)
            ADDR_TIMER_COUNT:  readMux[7:0] = timerCount_ff;
            ADDR_TIMER_CONFIG: readMux[7:0] = timerConfig_ff;
            ADDR_TIMER_STATUS: begin
                readMux[STS_PHASE_LSB +: 2] = phase_ff;
                readMux[STS_INH_LSB +: 2]   = inhibit_ff;
                readMux[STS_PSA_BIT]        = presToWdt;
            end
            default:           readMux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        // Reads land in phase two, writes in phase four
        targetPhase = pwrite ? PH_FOUR : PH_TWO;
        nxt_pready  = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata  = prdata_ff;
        if (accessPend && (nxt_phase == targetPhase)) begin
            nxt_pready  = 1'b1;
            nxt_pslverr = ~addrHit;
            if (!pwrite) begin
                // Read sampled at start of phase two
                nxt_prdata = readMux;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
        end
    end

    // ****************************************
    // Config register
    // ****************************************
    always_comb begin
        nxt_timerConfig = timerConfig_ff;
        if (wrConfig) begin
            nxt_timerConfig = pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timerConfig_ff <= CFG_RESET;
        end else begin
            timerConfig_ff <= nxt_timerConfig;
        end
    end

    // ****************************************
    // Write inhibit window
    // ****************************************
    always_comb begin
        nxt_inhibit = inhibit_ff;
        if (wrCount) begin
            nxt_inhibit = INHIBIT_CYCLES;
        end else if (cycleEnd && (inhibit_ff != 2'd0)) begin
            nxt_inhibit = inhibit_ff - 2'd1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            inhibit_ff <= 2'd0;
        end else begin
            inhibit_ff <= nxt_inhibit;
        end
    end

    // ****************************************
    // Timer count
    // ****************************************
    always_comb begin
        nxt_timerCount = timerCount_ff;
        if (wrCount) begin
            // Software write wins over a same-cycle increment
            nxt_timerCount = pwdata[7:0];
        end else if (timerTick && (inhibit_ff == 2'd0)) begin
            nxt_timerCount = timerCount_ff + 8'h01;
        end
    end

    // No reset: power-on value is unknown, other resets keep it
    always_ff @(posedge ref_clk) begin
        timerCount_ff <= nxt_timerCount;
    end

endmodule // tmz_timer0

// *** tmz_timer0_props.sv ***
// Concurrent checks on the timer block ports
`timescale 1ns/1ps
module tmz_timer0_props
    import tmz_pkg::*;
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // APB
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata_ff,
    input wire logic        pready_ff,
    input wire logic        pslverr_ff,
    // Core timing
    input wire logic [11:0] instrWord,
    input wire logic [3:0]  phaseVec_ff,
    input wire logic [7:0]  programCounter_ff,
    input wire logic [11:0] instrReg_ff,
    input wire logic        pipeFlush_ff
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_phase_rotate: assert property (1 |=>
        phaseVec_ff == {$past(phaseVec_ff[2:0]), $past(phaseVec_ff[3])})
        else $error("phase did not rotate");
    a_phase_onehot: assert property ($onehot(phaseVec_ff))
        else $error("phase not one-hot");
    a_hold_phase: assert property (!phaseVec_ff[0] |-> $stable(programCounter_ff))
        else $error("pc moved outside phase one");
    a_hold_ir: assert property (!phaseVec_ff[3] |-> $stable(instrReg_ff))
        else $error("ir moved outside phase four");
    a_pc_step: assert property (phaseVec_ff[0] && !pipeFlush_ff |->
        programCounter_ff == 8'($past(programCounter_ff) + 8'h01))
        else $error("pc did not step");
    // Reset parks the phase at four, so only a real entry into phase four counts
    a_ir_load: assert property (phaseVec_ff[3] && $past(phaseVec_ff[2]) |->
        instrReg_ff == ($past(pipeFlush_ff) ? 12'h000 : $past(instrWord)))
        else $error("ir load wrong");
    // A taken branch costs exactly one whole extra instruction cycle
    a_flush_len: assert property ($rose(pipeFlush_ff) |->
        phaseVec_ff[0] ##1 pipeFlush_ff [*3] ##1 !pipeFlush_ff)
        else $error("flush length wrong");
    a_ready_phase: assert property (pready_ff |->
        (pwrite ? phaseVec_ff[3] : phaseVec_ff[1]) ##1 !pready_ff)
        else $error("answer in wrong phase");
    a_slverr_map: assert property (pready_ff |->
        pslverr_ff == !(paddr == ADDR_TIMER_COUNT || paddr == ADDR_TIMER_CONFIG || paddr == ADDR_TIMER_STATUS))
        else $error("error response wrong");
    a_rdata_upper: assert property (pready_ff && !pwrite |-> prdata_ff[31:8] == 24'h000000)
        else $error("upper read bits set");
endmodule // tmz_timer0_props

bind tmz_timer0 tmz_timer0_props u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .pwrite(pwrite), .paddr(paddr), .prdata_ff(prdata_ff),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .instrWord(instrWord), .phaseVec_ff(phaseVec_ff),
    .programCounter_ff(programCounter_ff), .instrReg_ff(instrReg_ff), .pipeFlush_ff(pipeFlush_ff)
);

// *** tmz_core_model.sv ***
// Behavioural core and count pin facing the timer
`timescale 1ns/1ps
module tmz_core_model (
    // Clock
    input  wire logic       ref_clk,
    // Core side
    input  wire logic [7:0] programCounter_ff,
    output logic            branchReq,
    output logic [7:0]      branchTarget,
    output logic [11:0]     instrWord,
    // Pin and watchdog timebase
    output logic            extCountClockPin,
    output logic            wdtTickIn
);
    // Fetched word follows the program counter so ir loads are traceable
    assign instrWord = {programCounter_ff[3:0], programCounter_ff};

    initial begin
        branchReq        = 1'b0;
        branchTarget     = 8'h00;
        extCountClockPin = 1'b0;
        wdtTickIn        = 1'b0;
    end

    // Long settle covers the pin synchroniser
    task automatic set_pin(input logic v);
        @(posedge ref_clk);
        extCountClockPin <= v;
        repeat (48) @(posedge ref_clk);
    endtask

    task automatic wdt_ticks(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            wdtTickIn <= 1'b1;
            @(posedge ref_clk);
            wdtTickIn <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        // Last divided tick needs a few clocks to reach the output
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic branch(input logic [7:0] t);
        @(posedge ref_clk);
        branchReq    <= 1'b1;
        branchTarget <= t;
        @(posedge ref_clk);
        branchReq <= 1'b0;
    endtask
endmodule // tmz_core_model

// *** tmz_timer0_tb_top.sv ***
// Self-checking bench for the timer block
`timescale 1ns/1ps
module tmz_timer0_tb_top
    import tmz_pkg::*;
;
    logic        ref_clk, rst_n, psel, penable, pwrite, pready_ff, pslverr_ff;
    logic        extCountClockPin, wdtTickIn, wdtTick_ff, branchReq, pipeFlush_ff;
    logic [7:0]  paddr, branchTarget, programCounter_ff;
    logic [31:0] pwdata, prdata_ff;
    logic [11:0] instrWord, instrReg_ff;
    logic [3:0]  phaseVec_ff;
    int          nFail = 0;
    int          numChecks = 0;
    int          wdtSeen = 0;

    tmz_timer0 dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
        .pslverr_ff(pslverr_ff), .extCountClockPin(extCountClockPin), .wdtTickIn(wdtTickIn),
        .wdtTick_ff(wdtTick_ff), .branchReq(branchReq), .branchTarget(branchTarget),
        .instrWord(instrWord), .phaseVec_ff(phaseVec_ff), .programCounter_ff(programCounter_ff),
        .instrReg_ff(instrReg_ff), .pipeFlush_ff(pipeFlush_ff)
    );
    tmz_core_model core (
        .ref_clk(ref_clk), .programCounter_ff(programCounter_ff), .branchReq(branchReq),
        .branchTarget(branchTarget), .instrWord(instrWord), .extCountClockPin(extCountClockPin),
        .wdtTickIn(wdtTickIn)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (wdtTick_ff === 1'b1) wdtSeen <= wdtSeen + 1;
    end

    // ********************************
    // Tasks
    // ********************************
    task automatic end_of_test();
        $display("Checks %0d, failures %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            nFail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Leading edge keeps psel from being driven twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready_ff !== 1'b1 && n < 50);
        q = prdata_ff;
        err = pslverr_ff;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            nFail++;
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, 32'(d), q, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic expErr);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, 32'(exp));
        check(32'(e), 32'(expErr));
    endtask

    // Write returns at phase one; setup lands in phase three of cycle k
    task automatic count_after(input logic [7:0] v, input int k, output logic [7:0] got);
        logic [31:0] q;
        logic        e;
        wr(ADDR_TIMER_COUNT, v);
        repeat (4 * k - 3) @(posedge ref_clk);
        apb(1'b0, ADDR_TIMER_COUNT, 32'h0, q, e);
        got = q[7:0];
    endtask

    // ********************************
    // Sequence
    // ********************************
    initial begin
        logic [7:0] a;
        logic [7:0] b;
        int         w0;
        rst_n   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk(ADDR_TIMER_CONFIG, 8'hff, 1'b0);
        rd_chk(8'h10, 8'h00, 1'b1);
        wr(ADDR_TIMER_CONFIG, 8'h08);
        for (int k = 1; k <= 5; k++) begin
            count_after(8'hfe, k, a);
            check(32'(a), 32'(8'(8'hfe + (k > 2 ? k - 2 : 0))));
        end
        // Two runs differing by two prescaled periods give a delta of two
        for (int r = 0; r < 8; r++) begin
            wr(ADDR_TIMER_CONFIG, 8'(r));
            count_after(8'h00, 20, a);
            count_after(8'h00, 20 + (4 << r), b);
            check(32'(8'(b - a)), 32'h2);
        end
        for (int e = 0; e < 2; e++) begin
            core.set_pin(1'b0);
            wr(ADDR_TIMER_CONFIG, (e != 0) ? 8'h38 : 8'h28);
            wr(ADDR_TIMER_COUNT, 8'h00);
            repeat (12) @(posedge ref_clk);
            core.set_pin(1'b1);
            rd_chk(ADDR_TIMER_COUNT, (e != 0) ? 8'h00 : 8'h01, 1'b0);
            core.set_pin(1'b0);
            rd_chk(ADDR_TIMER_COUNT, 8'h01, 1'b0);
        end
        wr(ADDR_TIMER_CONFIG, 8'h08);
        w0 = wdtSeen;
        core.wdt_ticks(8);
        check(32'(wdtSeen - w0), 32'h4);
        wr(ADDR_TIMER_CONFIG, 8'h00);
        w0 = wdtSeen;
        core.wdt_ticks(8);
        check(32'(wdtSeen - w0), 32'h0);
        core.branch(8'h40);
        w0 = 0;
        do begin
            @(posedge ref_clk);
            #1;
            w0++;
        end while (phaseVec_ff !== 4'h1 && w0 < 8);
        check(32'(programCounter_ff), 32'h40);
        wr(ADDR_TIMER_CONFIG, 8'h28);
        wr(ADDR_TIMER_COUNT, 8'h5a);
        rst_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk(ADDR_TIMER_COUNT, 8'h5a, 1'b0);
        rd_chk(ADDR_TIMER_CONFIG, 8'hff, 1'b0);
        // Status: phase one at read sample, no inhibit, prescaler on watchdog
        rd_chk(ADDR_TIMER_STATUS, 8'h10, 1'b0);
        end_of_test();
    end
endmodule // tmz_timer0_tb_top
